/* rtl/fan_lock_pkg.sv */
// Purpose: constants and types for the fan lock-protect drive block
// Assumes: 100 MHz system clock
// Notes: times kept in ms, cycle counts derived from them
package fan_lock_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned LOCK_RETRY_ON_TIME_MS = 400;
	localparam int unsigned LOCK_RETRY_OFF_TIME_MS = 3000;
	localparam longint unsigned ON_CYCLES_L =
		longint'(CLK_HZ) / 64'd1000 * longint'(LOCK_RETRY_ON_TIME_MS);
	localparam longint unsigned OFF_CYCLES_L =
		longint'(CLK_HZ) / 64'd1000 * longint'(LOCK_RETRY_OFF_TIME_MS);
	localparam int unsigned ON_CYCLES = int'(ON_CYCLES_L);
	localparam int unsigned OFF_CYCLES = int'(OFF_CYCLES_L);
	localparam int unsigned TMR_W = 32;
	localparam logic RESET_HALL = 1'b0;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_OFF = 3'b010,
		ST_RETRY = 3'b100
	} lock_state_t;

	typedef struct packed {
		logic coil_drive_a;
		logic coil_drive_b;
		logic rotor_locked;
	} drive_out_t;
endpackage

/* rtl/hall_sync.sv */
// Purpose: two-stage synchroniser plus edge detect for the Hall level
// Assumes: input asynchronous to clk_sys_i
// Notes: edge detect reads only the second and third stages
`timescale 1ns/1ps
`default_nettype none
module hall_sync (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Hall level in
	input wire logic hall_i,
	// Synchronised level and edge pulse
	output logic hall_o,
	output logic edge_o
);
	import fan_lock_pkg::*;
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_q <= RESET_HALL;
			s2_q <= RESET_HALL;
			s3_q <= RESET_HALL;
		end else begin
			s1_q <= hall_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign hall_o = s2_q;
	assign edge_o = s2_q ^ s3_q;
endmodule
`default_nettype wire

/* rtl/fan_lock_protect_drive.sv */
// Purpose: coil commutation with rotor-lock shutdown and auto retry
// Assumes: Hall polarity level from the on-chip sensor, async
// Notes: coil outputs are active-high "transistor on" controls
`timescale 1ns/1ps
`default_nettype none
module fan_lock_protect_drive #(
	parameter int unsigned ON_CYC = fan_lock_pkg::ON_CYCLES,
	parameter int unsigned OFF_CYC = fan_lock_pkg::OFF_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Hall polarity, high = north
	input wire logic hall_pol_i,
	// Coil controls and rotor state
	output var fan_lock_pkg::drive_out_t drive_o,
	output logic coil_drive_a_o,
	output logic coil_drive_b_o,
	output logic rotor_state_o
);
	import fan_lock_pkg::*;

	localparam logic [TMR_W-1:0] ON_LAST = TMR_W'(ON_CYC - 1);
	localparam logic [TMR_W-1:0] OFF_LAST = TMR_W'(OFF_CYC - 1);

	logic hall_s;
	logic hall_edge;
	lock_state_t state_q;
	lock_state_t state_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	logic a_q;
	logic b_q;
	logic locked_q;

	hall_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.hall_i(hall_pol_i),
		.hall_o(hall_s),
		.edge_o(hall_edge)
	);

	// Timer end marks for each phase
	wire on_done = (tmr_q == ON_LAST);
	wire off_done = (tmr_q == OFF_LAST);
	// Next state, so coils drop on the edge that latches the lock
	wire drive_en = (state_d != ST_OFF);

	always_comb begin
		state_d = state_q;
		tmr_d = tmr_q + 1'b1;
		case (state_q)
			ST_RUN: begin
				if (hall_edge) begin
					tmr_d = '0;
				end else if (on_done) begin
					state_d = ST_OFF;
					tmr_d = '0;
				end
			end
			ST_OFF: begin
				if (off_done) begin
					state_d = ST_RETRY;
					tmr_d = '0;
				end
			end
			ST_RETRY: begin
				if (hall_edge) begin
					state_d = ST_RUN;
					tmr_d = '0;
				end else if (on_done) begin
					state_d = ST_OFF;
					tmr_d = '0;
				end
			end
			default: begin
				state_d = ST_OFF;
				tmr_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= ST_RUN;
			tmr_q <= '0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
		end
	end

	// Registered coil controls and latched rotor state
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			locked_q <= 1'b0;
		end else begin
			a_q <= drive_en & hall_s;
			b_q <= drive_en & ~hall_s;
			if (state_d == ST_RUN) begin
				locked_q <= 1'b0;
			end else begin
				locked_q <= 1'b1;
			end
		end
	end

	assign coil_drive_a_o = a_q;
	assign coil_drive_b_o = b_q;
	assign rotor_state_o = locked_q;
	assign drive_o = '{coil_drive_a: a_q, coil_drive_b: b_q,
		rotor_locked: locked_q};
endmodule
`default_nettype wire

/* test/fan_chk.sv */
// Purpose: port checks. Assumes: short counts. Notes: bound in bench.
`timescale 1ns/1ps
`default_nettype none
module fan_chk #(parameter int ON_CYC = 20, OFF_CYC = 100) (
	input wire logic clk_sys_i, rst_b_i, hall_pol_i,
	input wire logic coil_drive_a_o, coil_drive_b_o, rotor_state_o
);
	wire logic h = hall_pol_i;
	wire logic lk = rotor_state_o;
	wire logic on = coil_drive_a_o | coil_drive_b_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	a_one_coil: assert property ($past(rst_b_i) && !lk |->
		coil_drive_a_o ^ coil_drive_b_o) else $error("pair");
	a_coil_hall: assert property ($past(rst_b_i, 3) && !lk |->
		coil_drive_a_o == $past(h, 3)) else $error("hall");
	a_lock_off: assert property ($rose(lk) |-> !on) else $error("off");
	a_off_hold: assert property ($rose(lk) |-> ##(OFF_CYC-2) !on)
		else $error("gap");
	a_auto_retry: assert property ($rose(lk) |-> ##(OFF_CYC+2) on)
		else $error("retry");
	a_lock_latch: assert property ($rose(lk) |-> lk[*8])
		else $error("latch");
	a_retry_len: assert property (lk && $rose(on) |-> ##(ON_CYC-2) on)
		else $error("short");
	a_edge_hold: assert property ($past(h, 3) != $past(h, 4) && !lk
		|-> !lk[*8]) else $error("early");
endmodule
`default_nettype wire

/* test/fan_motor.sv */
// Purpose: rotor model. Assumes: spins while run_i. Notes: flips each 8.
`timescale 1ns/1ps
`default_nettype none
module fan_motor (
	input wire logic clk_sys_i,
	input wire logic run_i,
	output logic hall_o = 1'h0
);
	logic [2:0] t_q = 3'h0;
	always @(posedge clk_sys_i) if (run_i) t_q <= t_q + 3'h1;
	always @(posedge clk_sys_i) if (run_i && t_q == 3'h7) hall_o <= !hall_o;
endmodule
`default_nettype wire

/* test/testbench.sv */
// Purpose: bench. Assumes: 10 ns clock. Notes: row is jam, wait, want.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys_i = 1'h0;
	logic rst_b_i = 1'h0;
	logic jam = 1'h0;
	logic h, a, b, rs;
	logic [2:0] drv;
	int n_mismatch = 0;
	int n_compared = 0;
	wire logic [2:0] seen = {rs, a | b, a ^ b};
	logic [11:0] rows [6] = '{12'h143, 12'h944, 12'h9E4, 12'h8DF, 12'h95C,
		12'h4B3};
	initial forever #5 clk_sys_i = !clk_sys_i;
	fan_lock_protect_drive #(.ON_CYC(20), .OFF_CYC(100)) dut (.clk_sys_i,
		.rst_b_i, .hall_pol_i(h), .drive_o(drv), .coil_drive_a_o(a),
		.coil_drive_b_o(b), .rotor_state_o(rs));
	fan_motor motor (.clk_sys_i, .run_i((a | b) & !jam), .hall_o(h));
	task chk(input logic [2:0] s, e);
		n_compared++;
		if (s !== e) n_mismatch++;
		if (s !== e) $display("BAD %0t got %h", $time, s);
	endtask
	task give_verdict;
		$display("%0d checks, %0d bad", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#9000 n_mismatch++;
		give_verdict;
	end
	initial begin
		@(negedge clk_sys_i);
		chk({a, b, rs}, 3'h0);
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'h1;
		foreach (rows[i]) begin
			@(posedge clk_sys_i);
			jam <= rows[i][11];
			repeat (rows[i][10:3]) @(negedge clk_sys_i);
			chk(seen, rows[i][2:0]);
			chk(drv, {a, b, rs});
		end
		@(posedge clk_sys_i);
		rst_b_i <= 1'h0;
		@(negedge clk_sys_i);
		chk({a, b, rs}, 3'h0);
		@(posedge clk_sys_i);
		rst_b_i <= 1'h1;
		repeat (4) @(negedge clk_sys_i);
		chk(seen, 3'h3);
		give_verdict;
	end
endmodule
bind fan_lock_protect_drive fan_chk #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC))
	u_chk (.clk_sys_i, .rst_b_i, .hall_pol_i, .coil_drive_a_o,
	.coil_drive_b_o, .rotor_state_o);
`default_nettype wire
